// >>> rtl/ccr_pkg.sv
package ccr_pkg;

  localparam int CCR_AW = 10;
  localparam int CCR_DW = 8;
  localparam int CCR_NCFG = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [CCR_AW-1:0] CCR_OFS_PLL = 10'h010;
  localparam logic [CCR_AW-1:0] CCR_OFS_RATIO = 10'h1E0;
  localparam logic [CCR_AW-1:0] CCR_OFS_ROUTE = 10'h1E1;
  localparam logic [CCR_AW-1:0] CCR_OFS_UPD = 10'h232;
  localparam logic [CCR_AW-1:0] CCR_OFS_STAT = 10'h233;
  localparam logic [CCR_NCFG-1:0][CCR_AW-1:0] CCR_CFG_OFS =
    {CCR_OFS_ROUTE, CCR_OFS_RATIO, CCR_OFS_PLL};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CCR_DW-1:0] CCR_RST_PLL = 8'h01;
  localparam logic [CCR_DW-1:0] CCR_RST_RATIO = 8'h02;
  localparam logic [CCR_DW-1:0] CCR_RST_ROUTE = 8'h00;
  localparam logic [CCR_NCFG-1:0][CCR_DW-1:0] CCR_CFG_RST =
    {CCR_RST_ROUTE, CCR_RST_RATIO, CCR_RST_PLL};

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int CCR_PLL_MODE_LSB = 0;
  localparam int CCR_PLL_POL_BIT = 7;
  localparam int CCR_ROUTE_BYP_BIT = 0;
  localparam int CCR_ROUTE_SRC_BIT = 1;
  localparam int CCR_UPD_BIT = 0;
  localparam int CCR_RATIO_W = 3;
  localparam logic [1:0] CCR_MODE_ON = 2'h0;
  localparam logic [1:0] CCR_MODE_APD = 2'h1;
  localparam logic [CCR_RATIO_W-1:0] CCR_DIV_MIN = 3'h2;
  localparam logic [CCR_RATIO_W-1:0] CCR_DIV_MAX = 3'h6;
  localparam logic [CCR_RATIO_W-1:0] CCR_CODE_MAX = 3'h4;

  // ****************************************
  // Rate limits
  // ****************************************
  localparam int CCR_CLK_MHZ = 250;
  localparam int CCR_CHAN_MAX_MHZ = 1600;
  localparam int CCR_EXT_MAX_MHZ = 2400;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [CCR_DW-1:0] route;
    logic [CCR_DW-1:0] ratio;
    logic [CCR_DW-1:0] pll;
  } ccr_cfg_t;

endpackage : ccr_pkg

// >>> rtl/ccr_stage_reg.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_stage_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  input wire logic commit,
  output logic [W-1:0] staged,
  output logic [W-1:0] active
);
  import ccr_pkg::*;

  if (W < 1) begin : g_bad_w
    $error("ccr_stage_reg: width must be at least one");
  end

  // ****************************************
  // Shadow copy
  // ****************************************
  // shadow takes writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      staged <= RST;
    end else if (wr_en) begin
      staged <= wdata;
    end
  end

  // ****************************************
  // Active copy
  // ****************************************
  // copy on update
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active <= RST;
    end else if (commit) begin
      active <= staged;
    end
  end

endmodule : ccr_stage_reg
`default_nettype wire

// >>> rtl/ccr_div.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_div #(
  parameter int RW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_en,
  input wire logic [RW-1:0] ratio,
  output logic out_en
);
  import ccr_pkg::*;

  if (RW < CCR_RATIO_W) begin : g_bad_rw
    $error("ccr_div: ratio width too small for the largest division");
  end

  logic [RW-1:0] cnt;
  logic last;

  assign last = (cnt >= ratio - RW'(1));

  // ****************************************
  // Source tick counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (in_en) begin
      cnt <= last ? '0 : cnt + RW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_en <= 1'b0;
    end else begin
      out_en <= in_en && last;
    end
  end

endmodule : ccr_div
`default_nettype wire

// >>> rtl/ccr_clock_routing.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_clock_routing (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ccr_pkg::CCR_AW-1:0] reg_addr,
  input wire logic [ccr_pkg::CCR_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ccr_pkg::CCR_DW-1:0] reg_rdata,
  input wire logic ext_clk_en,
  input wire logic osc_clk_en,
  output logic dist_clk_en,
  output logic prescaler_clk_en,
  output logic pll_power_on,
  output logic pll_async_pd,
  output logic osc_power_on,
  output logic pfd_neg_polarity,
  output ccr_pkg::ccr_cfg_t active_cfg
);
  import ccr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [CCR_NCFG-1:0][CCR_DW-1:0] stg;
  logic [CCR_NCFG-1:0][CCR_DW-1:0] act;
  logic [CCR_NCFG-1:0] cfg_wr;
  ccr_cfg_t staged_cfg;
  logic upd_commit;
  logic act_byp;
  logic act_src;
  logic act_pll_on;
  logic [CCR_RATIO_W-1:0] act_code;
  logic [CCR_RATIO_W-1:0] div_ratio;
  logic src_en;
  logic div_in;
  logic div_out;
  logic pending;
  logic [CCR_DW-1:0] next_rdata;
  logic [CCR_DW-1:0] stat_word;
  logic [3:0] busy_run;

  // ****************************************
  // Register decode
  // ****************************************
  // update write strobe
  assign upd_commit = reg_wr && (reg_addr == CCR_OFS_UPD) && reg_wdata[CCR_UPD_BIT];

  // ****************************************
  // Staged and active registers
  // ****************************************
  for (genvar i = 0; i < CCR_NCFG; i++) begin : g_cfg
    assign cfg_wr[i] = reg_wr && (reg_addr == CCR_CFG_OFS[i]);

    ccr_stage_reg #(
      .W(CCR_DW),
      .RST(CCR_CFG_RST[i])
    ) u_reg (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(cfg_wr[i]),
      .wdata(reg_wdata),
      .commit(upd_commit),
      .staged(stg[i]),
      .active(act[i])
    );
  end

  assign staged_cfg = ccr_cfg_t'(stg);
  assign active_cfg = ccr_cfg_t'(act);
  assign pending = (staged_cfg != active_cfg);

  // ****************************************
  // Active field views
  // ****************************************
  assign act_byp = active_cfg.route[CCR_ROUTE_BYP_BIT];
  assign act_src = active_cfg.route[CCR_ROUTE_SRC_BIT];
  assign act_code = active_cfg.ratio[CCR_RATIO_W-1:0];
  assign act_pll_on = (active_cfg.pll[CCR_PLL_MODE_LSB +: 2] == CCR_MODE_ON);

  // ****************************************
  // PLL power and polarity
  // ****************************************
  // mode 01 keeps the PLL off
  assign pll_power_on = act_pll_on;
  assign pll_async_pd = (active_cfg.pll[CCR_PLL_MODE_LSB +: 2] == CCR_MODE_APD);

  assign pfd_neg_polarity = active_cfg.pll[CCR_PLL_POL_BIT];

  assign osc_power_on = act_src;

  // ****************************************
  // Source select
  // ****************************************
  // external input when clear
  assign src_en = act_src ? osc_clk_en : ext_clk_en;

  // ****************************************
  // Pre-divider
  // ****************************************
  // codes map to two through six
  assign div_ratio = (act_code > CCR_CODE_MAX) ? CCR_DIV_MAX : act_code + CCR_DIV_MIN;

  assign div_in = src_en && !act_byp;

  ccr_div #(
    .RW(CCR_RATIO_W)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_en(div_in),
    .ratio(div_ratio),
    .out_en(div_out)
  );

  // ****************************************
  // Distribution output
  // ****************************************
  // bypass skips the pre-divider
  // input tick passes at full rate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dist_clk_en <= 1'b0;
    end else begin
      dist_clk_en <= act_byp ? src_en : div_out;
    end
  end

  // ****************************************
  // Prescaler feed
  // ****************************************
  // external input to prescaler
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescaler_clk_en <= 1'b0;
    end else begin
      prescaler_clk_en <= act_pll_on && !act_src && ext_clk_en;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  assign stat_word = {4'h0, pending, act_byp, act_src, act_pll_on};

  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      CCR_OFS_PLL: next_rdata = staged_cfg.pll;
      CCR_OFS_RATIO: next_rdata = staged_cfg.ratio;
      CCR_OFS_ROUTE: next_rdata = staged_cfg.route;
      CCR_OFS_STAT: next_rdata = stat_word;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence rst_release_s;
    !$past(rst_n);
  endsequence

  sequence pre_path_s;
    !act_byp [*3];
  endsequence

  sequence ext_byp_tick_s;
    act_byp && !act_src && ext_clk_en;
  endsequence

  sequence osc_byp_tick_s;
    act_byp && act_src && osc_clk_en;
  endsequence

  pll_reset_off_a: assert property (
    rst_release_s |-> pll_async_pd && !pll_power_on && !prescaler_clk_en)
    else $error("PLL not powered down after reset");

  ratio_reset_a: assert property (
    rst_release_s |-> div_ratio == 3'h4 && !act_byp && !act_src)
    else $error("reset routing is not external through divide by four");

  commit_copy_a: assert property (
    upd_commit |=> active_cfg == $past(staged_cfg) && !pending)
    else $error("update write did not apply staged values");

  shadow_hold_a: assert property (
    !upd_commit |=> $stable(active_cfg))
    else $error("active setup changed without an update write");

  ext_source_a: assert property (
    ext_byp_tick_s |=> dist_clk_en)
    else $error("external tick not passed to distribution");

  osc_source_a: assert property (
    osc_byp_tick_s |=> dist_clk_en)
    else $error("oscillator tick not passed to distribution");

  bypass_idle_a: assert property (
    act_byp && !src_en |=> !dist_clk_en)
    else $error("bypass path ticked without a source tick");

  min_div_a: assert property (
    pre_path_s ##0 dist_clk_en |=> !dist_clk_en)
    else $error("pre-divider divided by less than two");

  prescaler_feed_a: assert property (
    act_pll_on && !act_src && ext_clk_en |=> prescaler_clk_en)
    else $error("external tick not fed to prescaler");

  osc_off_a: assert property (
    !act_src |-> !osc_power_on)
    else $error("oscillator powered with external source");

  polarity_sel_a: assert property (
    upd_commit && staged_cfg.pll[CCR_PLL_POL_BIT] |=> pfd_neg_polarity)
    else $error("polarity bit not applied");

  default_back_a: assert property (
    upd_commit && staged_cfg.pll == CCR_RST_PLL && staged_cfg.route == CCR_RST_ROUTE
    |=> pll_async_pd && !act_byp && !act_src)
    else $error("rewritten defaults differ from reset setup");

  // ****************************************
  // Register bus checks
  // ****************************************
  sequence pll_write_s;
    reg_wr && reg_addr == CCR_OFS_PLL;
  endsequence

  sequence ratio_write_s;
    reg_wr && reg_addr == CCR_OFS_RATIO;
  endsequence

  sequence route_write_s;
    reg_wr && reg_addr == CCR_OFS_ROUTE;
  endsequence

  pll_stage_a: assert property (
    pll_write_s |=> staged_cfg.pll == $past(reg_wdata))
    else $error("PLL control write not staged");

  ratio_stage_a: assert property (
    ratio_write_s |=> staged_cfg.ratio == $past(reg_wdata))
    else $error("ratio write not staged");

  route_stage_a: assert property (
    route_write_s |=> staged_cfg.route == $past(reg_wdata))
    else $error("routing write not staged");

  upd_ignore_a: assert property (
    reg_wr && reg_addr == CCR_OFS_UPD && !reg_wdata[CCR_UPD_BIT] |=> $stable(active_cfg))
    else $error("update write without bit zero applied values");

  route_read_a: assert property (
    reg_rd && reg_addr == CCR_OFS_ROUTE |=> reg_rdata == $past(staged_cfg.route))
    else $error("routing read did not return the staged value");

  upd_read_a: assert property (
    reg_rd && reg_addr == CCR_OFS_UPD |=> reg_rdata == '0)
    else $error("update register read not zero");

  // read data only after a read
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data shown without a read");

  // ****************************************
  // Power and routing checks
  // ****************************************
  // one PLL mode at a time
  pll_mode_excl_a: assert property (
    !(pll_power_on && pll_async_pd))
    else $error("PLL both running and powered down");

  osc_powered_a: assert property (
    act_src |-> osc_power_on)
    else $error("oscillator chosen but not powered");

  polarity_pos_a: assert property (
    upd_commit && !staged_cfg.pll[CCR_PLL_POL_BIT] |=> !pfd_neg_polarity)
    else $error("positive polarity not applied");

  presc_osc_a: assert property (
    act_src |=> !prescaler_clk_en)
    else $error("prescaler fed while oscillator chosen");

  // ****************************************
  // Pre-divider checks
  // ****************************************
  sequence pre_idle_s;
    (!act_byp && !src_en) [*2];
  endsequence

  pre_idle_a: assert property (
    pre_idle_s |=> !dist_clk_en)
    else $error("pre-divider ticked without source ticks");

  always_ff @(posedge clk) begin
    if (!rst_n || act_byp || !src_en || dist_clk_en) begin
      busy_run <= '0;
    end else if (busy_run != 4'hF) begin
      busy_run <= busy_run + 4'h1;
    end
  end

  pre_busy_a: assert property (
    busy_run <= 4'h7)
    else $error("pre-divider path stopped ticking");

endmodule : ccr_clock_routing
`default_nettype wire

// >>> dv/ccr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_host_model (
  input wire logic clk,
  output logic [ccr_pkg::CCR_AW-1:0] reg_addr,
  output logic [ccr_pkg::CCR_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  import ccr_pkg::*;
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ****
  // Bus cycles
  // ****
  task automatic wr(input logic [CCR_AW-1:0] a, input logic [CCR_DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [CCR_AW-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask : rd
  task automatic commit();
    wr(CCR_OFS_UPD, 8'h01);
  endtask : commit
  task automatic pll_on(input logic neg);
    wr(CCR_OFS_PLL, {neg, 5'h00, CCR_MODE_ON});
  endtask : pll_on
  function automatic logic [7:0] ratio_for(input int in_mhz);
    int n;
    n = 2;
    while (in_mhz > CCR_CHAN_MAX_MHZ * n && n < 6) n++;
    return 8'(n - 2);
  endfunction : ratio_for
endmodule : ccr_host_model
`default_nettype wire

// >>> dv/test_clock_source_routing_config.sv
`timescale 1ns/1ns
`default_nettype none
module test_clock_source_routing_config;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_clk_en = 1'b0;
  logic osc_clk_en = 1'b0;
  logic [CCR_AW-1:0] reg_addr;
  logic [CCR_DW-1:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, dist_clk_en, prescaler_clk_en, pll_power_on;
  logic pll_async_pd, osc_power_on, pfd_neg_polarity;
  ccr_cfg_t active_cfg;
  int mismatches = 0;
  int total_checks = 0;
  int k;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  always #2 clk = ~clk;
  ccr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  ccr_clock_routing dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk_en(ext_clk_en), .osc_clk_en(osc_clk_en), .dist_clk_en(dist_clk_en),
    .prescaler_clk_en(prescaler_clk_en), .pll_power_on(pll_power_on),
    .pll_async_pd(pll_async_pd), .osc_power_on(osc_power_on),
    .pfd_neg_polarity(pfd_neg_polarity), .active_cfg(active_cfg));
  // ****
  // Checking
  // ****
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic rd_chk(input logic [CCR_AW-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd_chk
  always @(posedge clk) begin
    if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  task automatic follow(input int n, input logic use_osc, input logic presc);
    logic p, q;
    p = 1'b0;
    q = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      check("dist_clk_en", dist_clk_en, p);
      check("prescaler_clk_en", prescaler_clk_en, q);
      p = use_osc ? osc_clk_en : ext_clk_en;
      q = ext_clk_en & presc;
      ext_clk_en <= (i < n - 1) ? 1'($urandom) : 1'b0;
      osc_clk_en <= (i < n - 1) ? 1'($urandom) : 1'b0;
    end
  endtask : follow
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (dist_clk_en !== 1'b1 && g < 20);
  endtask : gap
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report();
  end
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(14550));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("active_cfg", active_cfg, {CCR_RST_ROUTE, CCR_RST_RATIO, CCR_RST_PLL});
    check("pll_async_pd", pll_async_pd, 1'b1);
    check("osc_power_on", osc_power_on, 1'b0);
    rd_chk(CCR_OFS_PLL, 8'h01);
    rd_chk(CCR_OFS_RATIO, 8'h02);
    rd_chk(CCR_OFS_ROUTE, 8'h00);
    rd_chk(CCR_OFS_UPD, 8'h00);
    rd_chk(10'h011, 8'h00);
    $display("test reset done");
    host.wr(CCR_OFS_ROUTE, 8'h03);
    rd_chk(CCR_OFS_ROUTE, 8'h03);
    rd_chk(CCR_OFS_STAT, 8'h08);
    host.wr(CCR_OFS_UPD, 8'h02);
    @(negedge clk);
    check("route", active_cfg.route, 8'h00);
    host.commit();
    @(negedge clk);
    check("route", active_cfg.route, 8'h03);
    check("osc_power_on", osc_power_on, 1'b1);
    rd_chk(CCR_OFS_STAT, 8'h06);
    follow(40, 1'b1, 1'b0);
    $display("test staging done");
    host.wr(CCR_OFS_ROUTE, 8'h01);
    host.commit();
    @(negedge clk);
    check("osc_power_on", osc_power_on, 1'b0);
    follow(40, 1'b0, 1'b0);
    host.pll_on(1'b1);
    host.commit();
    @(negedge clk);
    check("pll_power_on", pll_power_on, 1'b1);
    check("pll_async_pd", pll_async_pd, 1'b0);
    check("pfd_neg_polarity", pfd_neg_polarity, 1'b1);
    follow(40, 1'b0, 1'b1);
    host.pll_on(1'b0);
    host.commit();
    @(negedge clk);
    check("pfd_neg_polarity", pfd_neg_polarity, 1'b0);
    $display("test bypass done");
    host.wr(CCR_OFS_ROUTE, 8'h00);
    for (int c = 0; c < 8; c++) begin
      d = {5'($urandom), 3'(c)};
      host.wr(CCR_OFS_RATIO, d);
      rd_chk(CCR_OFS_RATIO, d);
      host.commit();
      ext_clk_en <= 1'b1;
      gap(k);
      gap(k);
      gap(k);
      check("dist_gap", 24'(k), 24'(c < 5 ? c + 2 : 6));
    end
    ext_clk_en <= 1'b0;
    $display("test divider done");
    host.wr(CCR_OFS_PLL, CCR_RST_PLL);
    host.wr(CCR_OFS_RATIO, host.ratio_for(5000));
    host.wr(CCR_OFS_ROUTE, CCR_RST_ROUTE);
    host.commit();
    @(negedge clk);
    check("active_cfg", active_cfg, {CCR_RST_ROUTE, CCR_RST_RATIO, CCR_RST_PLL});
    check("pll_async_pd", pll_async_pd, 1'b1);
    rd_chk(CCR_OFS_STAT, 8'h00);
    $display("test defaults done");
    host.wr(CCR_OFS_ROUTE, 8'h03);
    host.pll_on(1'b1);
    host.commit();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("active_cfg", active_cfg, {CCR_RST_ROUTE, CCR_RST_RATIO, CCR_RST_PLL});
    check("pll_async_pd", pll_async_pd, 1'b1);
    check("pfd_neg_polarity", pfd_neg_polarity, 1'b0);
    rd_chk(CCR_OFS_ROUTE, CCR_RST_ROUTE);
    $display("test reset again done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : test_clock_source_routing_config
`default_nettype wire
